// ---- hw/ucg_defines.svh ----
`ifndef UCG_DEFINES_SVH
`define UCG_DEFINES_SVH
// register byte addresses
`define UCG_ADDR_CTRL      12'h000
`define UCG_ADDR_DIV_LOW   12'h004
`define UCG_ADDR_DIV_HIGH  12'h008
`define UCG_ADDR_STATUS    12'h00c
// control register fields
`define UCG_CTRL_SYNC_BIT  0
`define UCG_CTRL_DBL_BIT   1
`define UCG_CTRL_DIR_BIT   2
`define UCG_CTRL_POL_BIT   3
`define UCG_CTRL_TXEN_BIT  4
`define UCG_CTRL_PWR_BIT   5
`define UCG_CTRL_RESET     8'h20
// divisor width and reset
`define UCG_DIV_W          12
`define UCG_DIV_RESET      12'h000
// states per bit in each mode
`define UCG_SPB_NORMAL     5'h10
`define UCG_SPB_DOUBLE     5'h08
`define UCG_SPB_SYNC       5'h02
// axi responses
`define UCG_RESP_OKAY      2'b00
`define UCG_RESP_SLVERR    2'b10
`endif

// ---- hw/ucg_pkg.sv ----
package ucg_pkg;
  // clocking modes
  typedef enum logic [1:0] {
    UCG_ASYNC_NORMAL = 2'b00,
    UCG_ASYNC_DOUBLE = 2'b01,
    UCG_SYNC_MASTER  = 2'b10,
    UCG_SYNC_SLAVE   = 2'b11
  } ucg_mode_t;
endpackage

// ---- hw/ucg_clock_gen.sv ----
`timescale 1ns/1ps
`include "ucg_defines.svh"

module ucg_clock_gen (
  // clock, reset, enable
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  // axi4-lite write
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // axi4-lite read
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // transfer clock pin
  input  wire logic             transfer_clock_pin_i,
  output logic                  transfer_clock_pin_o,
  output logic                  transfer_clock_pin_oe_n,
  // clocks toward transmitter and receiver
  output logic                  rx_tick,
  output logic                  tx_bit_tick,
  output logic                  tx_change_strobe,
  output logic                  rx_sample_strobe,
  output logic [4:0]            rx_states_per_bit,
  output ucg_pkg::ucg_mode_t    mode
);
  import ucg_pkg::*;

  // all state of the block
  // one copy is registered, the other is built each cycle
  // bus, divisor and clock strobes all live here
  typedef struct packed {
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic             aw_held;
    logic [11:0]      aw_addr;
    logic             w_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic [7:0]       ctrl;
    logic [11:0]      divisor;
    logic [11:0]      count;
    logic [3:0]       tx_div;
    logic             sync_ff1;
    logic             sync_ff2;
    logic             xck_prev;
    logic             xck_out;
    logic             rx_tick;
    logic             tx_bit_tick;
    logic             tx_change;
    logic             rx_sample;
    logic [4:0]       spb;
    ucg_mode_t        mode;
    logic             pin_o;
    logic             pin_oe_n;
  } ucg_state_t;

  ucg_state_t st_q;    // registered state
  ucg_state_t st_d;    // next state

  // mode from control bits
  // direction bit only matters once the sync bit is set
  function automatic ucg_mode_t mode_of(input logic [7:0] c);
    if (!c[`UCG_CTRL_SYNC_BIT]) begin
      // double speed only counts when asynchronous
      mode_of = c[`UCG_CTRL_DBL_BIT] ? UCG_ASYNC_DOUBLE : UCG_ASYNC_NORMAL;
    end else begin
      // direction bit set means pin is output, so master
      mode_of = c[`UCG_CTRL_DIR_BIT] ? UCG_SYNC_MASTER : UCG_SYNC_SLAVE;
    end
  endfunction

  // states per bit for a mode
  // the receiver recovery counts this many states per bit
  function automatic logic [4:0] spb_of(input ucg_mode_t m);
    unique case (m)
      UCG_ASYNC_NORMAL: spb_of = `UCG_SPB_NORMAL;
      UCG_ASYNC_DOUBLE: spb_of = `UCG_SPB_DOUBLE;
      // both sync modes use two states per bit
      UCG_SYNC_MASTER:  spb_of = `UCG_SPB_SYNC;
      UCG_SYNC_SLAVE:   spb_of = `UCG_SPB_SYNC;
    endcase
  endfunction

  // register read mux
  // read data is captured when the address is taken
  // unused addresses read as zero
  // status shows synced pin, pin drive, mode and counter top
  function automatic logic [31:0] read_of(input logic [11:0] a, input ucg_state_t s);
    unique case (a)
      `UCG_ADDR_CTRL:     read_of = {24'h000000, s.ctrl};
      `UCG_ADDR_DIV_LOW:  read_of = {24'h000000, s.divisor[7:0]};
      `UCG_ADDR_DIV_HIGH: read_of = {28'h0000000, s.divisor[11:8]};
      `UCG_ADDR_STATUS:   read_of = {25'h0000000, s.sync_ff2, s.pin_o, s.mode, s.count[11:9]};
      default:            read_of = 32'h00000000;
    endcase
  endfunction

  // address is one of ours
  // anything else answers with a slave error
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `UCG_ADDR_CTRL) || (a == `UCG_ADDR_DIV_LOW) ||
             (a == `UCG_ADDR_DIV_HIGH) || (a == `UCG_ADDR_STATUS);
  endfunction

  // helpers built inside the next-state process
  logic       do_write;   // both write halves held, response free
  logic       low_write;  // divisor low byte written this cycle
  logic       zero_hit;   // down-counter at zero
  logic       powered;    // channel clocked
  logic       xck_rise;   // slave clock rising edge
  logic       xck_fall;   // slave clock falling edge
  logic       edge_rise;  // chosen rising edge for pin logic
  logic       edge_fall;  // chosen falling edge
  logic [3:0] tx_max;     // transmit divider terminal

  // next-state logic
  // defaults hold every field, later branches override
  always_comb begin
    st_d      = st_q;
    low_write = 1'b0;
    // the response register must be free before a new write lands
    do_write  = st_q.aw_held && st_q.w_held && !st_q.bvalid;
    // accept address and data in either order
    if (s_axi_awvalid && st_q.awready) begin
      // hold the address until the data half arrives
      st_d.aw_held = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
      st_d.awready = 1'b0;
    end
    if (s_axi_wvalid && st_q.wready) begin
      // hold data and strobes until the address arrives
      st_d.w_held = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
      st_d.wready = 1'b0;
    end
    // perform the write once both halves are held
    if (do_write) begin
      // clear both halves and raise the response
      st_d.aw_held = 1'b0;
      st_d.w_held  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = mapped(st_q.aw_addr) ? `UCG_RESP_OKAY : `UCG_RESP_SLVERR;
      // only the low byte lane carries register data
      if (st_q.w_strb[0]) begin
        unique case (st_q.aw_addr)
          `UCG_ADDR_CTRL: begin
            // control bits take effect next cycle
            st_d.ctrl = st_q.w_data[7:0];
          end
          `UCG_ADDR_DIV_LOW: begin
            // low byte write also restarts the counter
            st_d.divisor[7:0] = st_q.w_data[7:0];
            low_write = 1'b1;
          end
          `UCG_ADDR_DIV_HIGH: begin
            // high nibble waits for the next reload
            st_d.divisor[11:8] = st_q.w_data[3:0];
          end
          default: begin
            // status and holes are not writable
          end
        endcase
      end
    end
    // free the write channels after the response is taken
    if (st_q.bvalid && s_axi_bready) begin
      // a new write may start only after this
      st_d.bvalid  = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready  = 1'b1;
    end
    // read: one at a time, answered the cycle after it is taken
    if (s_axi_arvalid && st_q.arready) begin
      // sample data at the take, answer next cycle
      st_d.arready = 1'b0;
      st_d.rvalid  = 1'b1;
      st_d.rdata   = read_of(s_axi_araddr, st_q);
      st_d.rresp   = mapped(s_axi_araddr) ? `UCG_RESP_OKAY : `UCG_RESP_SLVERR;
    end
    if (st_q.rvalid && s_axi_rready) begin
      // ready again once the data is taken
      st_d.rvalid  = 1'b0;
      st_d.arready = 1'b1;
    end

    // mode decode and receiver states per bit
    // mode lags ctrl by one cycle and spb by two
    // power cut bit high means the channel is unclocked
    st_d.mode = mode_of(st_q.ctrl);
    st_d.spb  = spb_of(st_q.mode);
    powered   = !st_q.ctrl[`UCG_CTRL_PWR_BIT];

    // baud down-counter
    // period is divisor plus one system cycles
    zero_hit = (st_q.count == 12'h000);
    // power cut keeps the counter parked at the reload value
    if (!powered || low_write) begin
      st_d.count = st_d.divisor;
    end else if (zero_hit) begin
      // reload picks up a new high nibble
      st_d.count = st_q.divisor;
    end else begin
      st_d.count = st_q.count - 12'h001;
    end
    // tick is skipped on the cycle of a low byte reload
    st_d.rx_tick = powered && zero_hit && !low_write;

    // transmitter divider on the baud tick
    // terminal count is one less than the divide ratio
    unique case (st_q.mode)
      UCG_ASYNC_NORMAL: tx_max = 4'hf;
      UCG_ASYNC_DOUBLE: tx_max = 4'h7;
      default:          tx_max = 4'h1;
    endcase
    st_d.tx_bit_tick = 1'b0;
    if (!powered) begin
      // restart the divider when power returns
      st_d.tx_div = 4'h0;
    end else if (st_q.rx_tick) begin
      // count baud ticks, wrap at the terminal count
      if (st_q.tx_div >= tx_max) begin
        st_d.tx_div      = 4'h0;
        // slave mode has no internal bit clock
        st_d.tx_bit_tick = (st_q.mode != UCG_SYNC_SLAVE);
      end else begin
        st_d.tx_div = st_q.tx_div + 4'h1;
      end
    end

    // slave clock: two-stage synchroniser, then edge detector
    // only the second stage feeds the edge detector
    // the first stage may go metastable, nothing else reads it
    st_d.sync_ff1 = transfer_clock_pin_i;
    st_d.sync_ff2 = st_q.sync_ff1;
    st_d.xck_prev = st_q.sync_ff2;
    xck_rise = st_q.sync_ff2 && !st_q.xck_prev;
    xck_fall = !st_q.sync_ff2 && st_q.xck_prev;

    // master clock toggles each transmit bit tick
    // idle at the polarity level so the first edge is the leading one
    if (st_q.mode != UCG_SYNC_MASTER || !powered) begin
      // outside master mode the drive rests at the polarity level
      st_d.xck_out = st_q.ctrl[`UCG_CTRL_POL_BIT];
    end else if (st_q.tx_bit_tick) begin
      st_d.xck_out = !st_q.xck_out;
    end
    // master edges are known one cycle before the pin moves
    edge_rise = (st_q.mode == UCG_SYNC_MASTER) ? (st_q.tx_bit_tick && !st_q.xck_out) : xck_rise;
    edge_fall = (st_q.mode == UCG_SYNC_MASTER) ? (st_q.tx_bit_tick && st_q.xck_out) : xck_fall;

    // polarity picks change and sample edges; asynchronous uses the pin for nothing
    if (st_q.ctrl[`UCG_CTRL_SYNC_BIT] && powered) begin
      // polarity zero: change on rise, sample on fall
      st_d.tx_change = st_q.ctrl[`UCG_CTRL_POL_BIT] ? edge_fall : edge_rise;
      st_d.rx_sample = st_q.ctrl[`UCG_CTRL_POL_BIT] ? edge_rise : edge_fall;
    end else begin
      // asynchronous modes leave the pin to port logic
      st_d.tx_change = 1'b0;
      st_d.rx_sample = 1'b0;
    end

    // pin driven only by a synchronous master with transmitter on
    // drive value lags the internal clock by one cycle
    // the peer must leave the pin alone while enable is low
    st_d.pin_o    = st_q.xck_out;
    st_d.pin_oe_n = !(st_q.mode == UCG_SYNC_MASTER && st_q.ctrl[`UCG_CTRL_TXEN_BIT] && powered);

    // synchronous reset to constants
    // clears everything, then sets the nonzero reset values
    if (!aresetn) begin
      st_d = '0;
      st_d.awready  = 1'b1;
      st_d.wready   = 1'b1;
      st_d.arready  = 1'b1;
      st_d.ctrl     = `UCG_CTRL_RESET;
      st_d.divisor  = `UCG_DIV_RESET;
      st_d.spb      = `UCG_SPB_NORMAL;
      st_d.mode     = UCG_ASYNC_NORMAL;
      st_d.pin_oe_n = 1'b1;
    end
  end

  // state register, frozen while the enable is low (reset still acts)
  // a frozen block keeps its strobes as they were until the enable returns
  always_ff @(posedge aclk) begin
    if (clk_en || !aresetn) begin
      st_q <= st_d;
    end
  end

  // outputs straight from flip-flops
  // no logic between the state and the pins
  // axi handshakes and read data
  assign s_axi_awready           = st_q.awready;
  assign s_axi_wready            = st_q.wready;
  assign s_axi_bresp             = st_q.bresp;
  assign s_axi_bvalid            = st_q.bvalid;
  assign s_axi_arready           = st_q.arready;
  assign s_axi_rdata             = st_q.rdata;
  assign s_axi_rresp             = st_q.rresp;
  assign s_axi_rvalid            = st_q.rvalid;
  // link pin and clock strobes
  assign transfer_clock_pin_o    = st_q.pin_o;
  assign transfer_clock_pin_oe_n = st_q.pin_oe_n;
  assign rx_tick                 = st_q.rx_tick;
  assign tx_bit_tick             = st_q.tx_bit_tick;
  assign tx_change_strobe        = st_q.tx_change;
  assign rx_sample_strobe        = st_q.rx_sample;
  assign rx_states_per_bit       = st_q.spb;
  assign mode                    = st_q.mode;
endmodule

// ---- tb/ucg_clock_gen_asserts.sv ----
`timescale 1ns/1ps
// watches the clock unit outputs against mode and bus inputs
module ucg_clock_gen_asserts (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // bus handshakes
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  // clock outputs
  input wire logic       transfer_clock_pin_oe_n,
  input wire logic       tx_bit_tick,
  input wire logic       tx_change_strobe,
  input wire logic       rx_sample_strobe,
  input wire logic [4:0] rx_states_per_bit,
  input ucg_pkg::ucg_mode_t mode
);
  import ucg_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_spb_norm; $stable(mode) && mode == UCG_ASYNC_NORMAL |-> rx_states_per_bit == 5'h10; endproperty
  property p_spb_dbl; $stable(mode) && mode == UCG_ASYNC_DOUBLE |-> rx_states_per_bit == 5'h08; endproperty
  property p_spb_sync; $stable(mode) && mode[1] |-> rx_states_per_bit == 5'h02; endproperty
  property p_async; $stable(mode) && !mode[1] |-> transfer_clock_pin_oe_n && !tx_change_strobe && !rx_sample_strobe;
  endproperty
  property p_slave; $stable(mode) && mode == UCG_SYNC_SLAVE |-> transfer_clock_pin_oe_n && !tx_bit_tick; endproperty
  property p_opp; !(tx_change_strobe && rx_sample_strobe); endproperty
  property p_txdiv; tx_bit_tick |=> !tx_bit_tick; endproperty
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_spb_norm: assert property (p_spb_norm) else $error("spb not 16");
  a_spb_dbl: assert property (p_spb_dbl) else $error("spb not 8");
  a_spb_sync: assert property (p_spb_sync) else $error("spb not 2");
  a_async: assert property (p_async) else $error("pin used in async");
  a_slave: assert property (p_slave) else $error("slave drives pin");
  a_opp: assert property (p_opp) else $error("both strobes");
  a_txdiv: assert property (p_txdiv) else $error("tx tick too fast");
  a_rd: assert property (p_rd) else $error("late read answer");
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  c_tx: cover property (tx_bit_tick);
  c_smp: cover property (rx_sample_strobe);
  c_chg: cover property (tx_change_strobe);
endmodule

// ---- tb/ucg_peer_model.sv ----
`timescale 1ns/1ps
// remote peer clock source, toggles every 8 system cycles
module ucg_peer_model (
  // clock and control
  input wire logic aclk,
  input wire logic run,
  input wire logic idle_lvl,
  // transfer clock out
  output logic     pin
);
  int cnt = 0;  // cycles since last edge
  // half period 8 keeps the rate at 1/16 of system clock
  always @(posedge aclk) begin
    if (!run) begin
      cnt <= 0;
      pin <= idle_lvl;
    end else if (cnt == 7) begin
      cnt <= 0;
      pin <= !pin;
    end else
      cnt <= cnt + 1;
  end
endmodule

// ---- tb/tb_usart_clock_generator.sv ----
`timescale 1ns/1ps
`include "ucg_defines.svh"
module tb_usart_clock_generator;
  import ucg_pkg::*;
  logic aclk = 0, aresetn = 0, clk_en = 1, run = 0, idle = 0, p0, peer_pin, pin_w;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic transfer_clock_pin_o, transfer_clock_pin_oe_n, rx_tick, tx_bit_tick, tx_change_strobe, rx_sample_strobe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_r;
  logic [4:0]  rx_states_per_bit;
  ucg_mode_t   mode;
  int err_count = 0, checked = 0, seed = 21277, g, d, i, n;
  int cv[5] = '{'h10, 'h12, 'h15, 'h1d, 'h17};
  int dv[5] = '{16, 8, 2, 2, 2};
  // pin level from both drivers
  assign pin_w = transfer_clock_pin_oe_n === 1'b0 ? transfer_clock_pin_o : peer_pin;
  always #10 aclk = ~aclk;
  ucg_clock_gen dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .transfer_clock_pin_i(pin_w), .transfer_clock_pin_o, .transfer_clock_pin_oe_n, .rx_tick, .tx_bit_tick,
    .tx_change_strobe, .rx_sample_strobe, .rx_states_per_bit, .mode);
  ucg_peer_model peer (.aclk, .run, .idle_lvl(idle), .pin(peer_pin));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  // one write, held until each channel is taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int k;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1 && k < 100);
    s_axi_bready <= 0;
    chk("b_wait", 1, k < 100);
    chk("bresp", (a > `UCG_ADDR_STATUS || a[1:0] != 2'b00) ? `UCG_RESP_SLVERR : `UCG_RESP_OKAY, s_axi_bresp);
    @(posedge aclk);
  endtask
  // one read, result in rd_d and rd_r
  task automatic rd(input logic [11:0] a);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1 && k < 100);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    chk("r_wait", 1, k < 100);
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  // cycles between two ticks, pin level kept at the first
  task automatic gap(input logic w, output int c);
    c = 0;
    while ((w ? tx_bit_tick : rx_tick) !== 1'b1 && c < 9000) begin
      @(posedge aclk);
      c++;
    end
    p0 = transfer_clock_pin_o;
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while ((w ? tx_bit_tick : rx_tick) !== 1'b1 && c < 9000);
    chk("tick_wait", 1, c < 9000);
  endtask
  task automatic complete_run;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`UCG_ADDR_CTRL);
    chk("ctrl_reset", `UCG_CTRL_RESET, rd_d);
    rd(`UCG_ADDR_DIV_LOW);
    chk("div_reset", `UCG_DIV_RESET, rd_d);
    rd(12'h010);
    chk("bad_resp", `UCG_RESP_SLVERR, rd_r);
    chk("bad_data", 0, rd_d);
    wr(12'h010, 0);
    wr(`UCG_ADDR_DIV_LOW, 3);
    n = 0;
    repeat (40) begin
      @(posedge aclk);
      if (rx_tick !== 1'b0) n++;
    end
    chk("tick_off", 0, n);
    s_axi_wstrb <= 0;
    wr(`UCG_ADDR_DIV_LOW, 'h55);
    s_axi_wstrb <= 4'hf;
    rd(`UCG_ADDR_DIV_LOW);
    chk("strb_off", 3, rd_d);
    wr(`UCG_ADDR_CTRL, 'h10);
    for (i = 0; i < 4; i++) begin
      d = i == 0 ? 0 : i == 3 ? 4095 : $random(seed) & 'h1ff;
      wr(`UCG_ADDR_DIV_HIGH, d >> 8);
      wr(`UCG_ADDR_DIV_LOW, d & 'hff);
      gap(0, g);
      chk("rx_gap", d + 1, g);
      rd(`UCG_ADDR_DIV_HIGH);
      chk("div_high", d >> 8, rd_d);
    end
    d = 2 + ($random(seed) & 7);
    wr(`UCG_ADDR_DIV_HIGH, 0);
    wr(`UCG_ADDR_DIV_LOW, d);
    for (i = 0; i < 5; i++) begin
      wr(`UCG_ADDR_CTRL, cv[i]);
      gap(1, g);
      gap(1, g);
      chk("tx_gap", dv[i] * (d + 1), g);
      chk("spb", dv[i], rx_states_per_bit);
      chk("mode", i < 2 ? i : 2, mode);
      chk("oe_n", i < 2, transfer_clock_pin_oe_n);
      if (i > 1) chk("pin_toggle", !p0, transfer_clock_pin_o);
      rd(`UCG_ADDR_STATUS);
      chk("status_mode", i < 2 ? i : 2, rd_d[4:3]);
    end
    for (i = 0; i < 2; i++) begin
      wr(`UCG_ADDR_CTRL, i ? 'h19 : 'h11);
      chk("mode_slave", UCG_SYNC_SLAVE, mode);
      idle <= i[0];
      run <= 1;
      repeat (6) begin
        n = 0;
        do begin
          @(posedge aclk);
          n++;
        end while (rx_sample_strobe !== 1'b1 && tx_change_strobe !== 1'b1 && n < 100);
        chk("strobe_seen", 1, n < 100);
        chk("pin_at_strobe", rx_sample_strobe === 1'b1 ? i[0] : !i[0], pin_w);
      end
      run <= 0;
      repeat (8) @(posedge aclk);
    end
    // enable low for five edges stretches one tick gap by five
    gap(0, g);
    clk_en <= 0;
    fork
      gap(0, g);
      begin
        repeat (5) @(posedge aclk);
        clk_en <= 1;
      end
    join
    chk("freeze_gap", d + 6, g);
    complete_run();
  end
endmodule
bind ucg_clock_gen ucg_clock_gen_asserts u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_bvalid, .s_axi_bready, .transfer_clock_pin_oe_n, .tx_bit_tick, .tx_change_strobe, .rx_sample_strobe,
  .rx_states_per_bit, .mode);
